/* File: bench/cfbs_can_node.sv */
// Behavioural protocol engine reporting filter hits
`timescale 1ns/1ps
module cfbs_can_node (
  output logic accept_valid,
  output logic [3:0] accept_filter,
  output logic msg_done,
  input wire logic pclk
);
  // Quiet between frames
  initial begin
    accept_valid = 1'b0;
    accept_filter = 4'h0;
    msg_done = 1'b0;
  end
  // Hit first, completion after a gap; index scrambled once stale
  task automatic send(input logic [3:0] f, input int gap);
    @(posedge pclk);
    accept_valid <= 1'b1;
    accept_filter <= f;
    @(posedge pclk);
    accept_valid <= 1'b0;
    accept_filter <= ~f;
    repeat (gap) @(posedge pclk);
    msg_done <= 1'b1;
    @(posedge pclk);
    msg_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
endmodule // cfbs_can_node

/* File: bench/cfbs_steer_monitor.sv */
// Port checker for the steering block
`timescale 1ns/1ps
module cfbs_steer_monitor #(
  parameter int NUM_FILTERS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic msg_done,
  input wire logic buf_wr_ff,
  input wire logic [3:0] buf_idx_ff,
  input wire logic fifo_wr_ff,
  input wire logic [NUM_FILTERS-1:0] filter_enable_ff
);
  // One domain, so one clocking and one disable
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_fifo_cause: assert property (fifo_wr_ff |-> $past(msg_done))
    else $error("fifo write without completion");
  a_buf_cause: assert property (buf_wr_ff |-> $past(msg_done))
    else $error("buffer write without completion");
  a_one_dest: assert property (!(buf_wr_ff && fifo_wr_ff))
    else $error("message sent to two places");
  a_idx_range: assert property (buf_wr_ff |-> buf_idx_ff < 4'hf)
    else $error("buffer number out of range");
  a_idx_hold: assert property (!buf_wr_ff |-> $stable(buf_idx_ff))
    else $error("buffer number moved while idle");
  a_en_reset: assert property ($rose(presetn) |-> &filter_enable_ff)
    else $error("enables not set after reset");
endmodule // cfbs_steer_monitor

bind cfbs_steer cfbs_steer_monitor #(.NUM_FILTERS(NUM_FILTERS)) mon (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .msg_done(msg_done),
  .buf_wr_ff(buf_wr_ff),
  .buf_idx_ff(buf_idx_ff),
  .fifo_wr_ff(fifo_wr_ff),
  .filter_enable_ff(filter_enable_ff)
);

/* File: bench/cfbs_steer_tb_top.sv */
// Self-checking bench for the steering block
`timescale 1ns/1ps
`define CHK(n, x, s) begin checked++; if ((s) !== (x)) begin \
  err_count++; $display("ERROR %s exp %h got %h", n, x, s); end end
module cfbs_steer_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, acc_v, done, bwr, fwr, irq;
  logic [3:0] acc_f, bidx;
  logic [3:0] last_buf = 4'h0;
  logic [15:0] fen;
  int err_count = 0;
  int checked = 0;
  int nbuf = 0;
  int nfifo = 0;
  always #2.5 pclk = ~pclk;
  cfbs_steer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .accept_valid(acc_v), .accept_filter(acc_f), .msg_done(done),
    .buf_wr_ff(bwr), .buf_idx_ff(bidx), .fifo_wr_ff(fwr),
    .filter_enable_ff(fen), .irq_ff(irq));
  cfbs_can_node node (.accept_valid(acc_v), .accept_filter(acc_f),
    .msg_done(done), .pclk(pclk));
  // Tally strobes as they land
  always @(posedge pclk) begin
    if (bwr === 1'b1) begin
      nbuf <= nbuf + 1;
      last_buf <= bidx;
    end
    if (fwr === 1'b1)
      nfifo <= nfifo + 1;
  end
  // Hold the request until ready is seen
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("rdata", x, q)
  endtask
  task t_reset;
    for (int r = 0; r < 4; r++) rd(8'(4 * r), 32'h0);
    rd(cfbs_pkg::OFS_ENABLE, 32'hffff);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("slverr", 1'b1, e)
  endtask
  // Automatic so the table initialiser is legal inside the task
  task automatic t_map;
    logic [15:0] p [4] = '{16'h3210, 16'h7654, 16'hba98, 16'hfedc};
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'(4 * r), {16'h0, p[r]});
      rd(8'(4 * r), {16'h0, p[r]});
    end
    for (int f = 0; f < 15; f++) begin
      node.send(4'(f), 1);
      `CHK("buffer", 4'(f), last_buf)
      apb(1'b1, cfbs_pkg::OFS_FULL, 32'h0);
    end
    node.send(4'hf, 0);
    `CHK("fifo", 1, nfifo)
    `CHK("writes", 15, nbuf)
  endtask
  task t_ovf;
    node.send(4'h2, 0);
    rd(cfbs_pkg::OFS_FULL, 32'h4);
    node.send(4'h2, 0);
    `CHK("dropped", 16, nbuf)
    rd(cfbs_pkg::OFS_OVF, 32'h4);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, cfbs_pkg::OFS_IRQ_MASK, 32'h4);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b1, irq)
    apb(1'b1, cfbs_pkg::OFS_IRQ_STAT, 32'h4);
    repeat (2) @(posedge pclk);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, cfbs_pkg::OFS_OVF, 32'h0);
    apb(1'b1, cfbs_pkg::OFS_FULL, 32'h0);
    rd(cfbs_pkg::OFS_FULL, 32'h0);
    rd(cfbs_pkg::OFS_OVF, 32'h0);
  endtask
  task t_enable;
    apb(1'b1, cfbs_pkg::OFS_ENABLE, 32'hfffe);
    // Write lands on the edge apb returns at; look one edge later
    @(posedge pclk);
    `CHK("enable", 16'hfffe, fen)
    node.send(4'h0, 0);
    `CHK("disabled", 16, nbuf)
    apb(1'b1, cfbs_pkg::OFS_ENABLE, 32'hffff);
  endtask
  // Field rewritten mid-message must not move that message
  task t_sample;
    fork
      node.send(4'h1, 6);
      apb(1'b1, cfbs_pkg::OFS_DEST0, 32'h3250);
    join
    `CHK("buffer", 4'h1, last_buf)
    apb(1'b1, cfbs_pkg::OFS_FULL, 32'h0);
    node.send(4'h1, 0);
    `CHK("buffer", 4'h5, last_buf)
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_map;
    t_ovf;
    t_enable;
    t_sample;
    wrap_up;
  end
  // Run needs under a thousand cycles; ample margin
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    wrap_up;
  end
endmodule // cfbs_steer_tb_top

/* File: inc/cfbs_pkg.sv */
// Constants and types for the CAN filter buffer steering block
// Overview of operation
// - Filters 0-3 destinations in first register
// - Filters 4-7 destinations in second register
// - Filters 8-11 destinations in third register
// - Destination 1111 stores message in FIFO
// - Destination 0-14 stores in that buffer
// - Destination fields read/write, reset to zero
// - Only enabled filters steer messages
// - Buffer write sets full; software clears
// - Hit on full buffer sets overflow flag
package cfbs_pkg;
  localparam int NUM_FILTERS = 16;
  localparam int NUM_BUFS = 15;
  localparam int DEST_W = 4;
  localparam logic [3:0] DEST_FIFO = 4'hf;
  // Register byte offsets
  localparam logic [7:0] OFS_DEST0 = 8'h00;
  localparam logic [7:0] OFS_DEST1 = 8'h04;
  localparam logic [7:0] OFS_DEST2 = 8'h08;
  localparam logic [7:0] OFS_DEST3 = 8'h0c;
  localparam logic [7:0] OFS_ENABLE = 8'h10;
  localparam logic [7:0] OFS_FULL = 8'h14;
  localparam logic [7:0] OFS_OVF = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFS_LAST_HIT = 8'h24;
  // Reset values
  localparam logic [15:0] RST_DEST = 16'h0000;
  localparam logic [15:0] RST_ENABLE = 16'hffff;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;
  // Interrupt status bit positions
  localparam int IRQ_BUF = 0;
  localparam int IRQ_FIFO = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_W = 3;
  typedef enum logic [2:0] {
    CFBS_IDLE = 3'b001,
    CFBS_STORE = 3'b010,
    CFBS_DROP = 3'b100
  } cfbs_state_t;
endpackage

/* File: src/cfbs_dest_select.sv */
`timescale 1ns/1ps
// Per-filter destination field slicing and hit selection
module cfbs_dest_select #(
  parameter int NUM_FILTERS = 16
) (
  input wire logic [63:0] dest_regs,
  input wire logic [3:0] hit_index,
  output logic [3:0] dest_out
);
  logic [3:0] field [NUM_FILTERS];

  // Filter n lives in nibble n of the packed four registers
  genvar g;
  generate
    for (g = 0; g < NUM_FILTERS; g++) begin : g_field
      assign field[g] = dest_regs[4*g +: 4];
    end
  endgenerate

  assign dest_out = field[hit_index];
endmodule // cfbs_dest_select

/* File: src/cfbs_steer.sv */
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// CAN receive filter-hit to buffer steering with APB registers
module cfbs_steer #(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_BUFS = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic accept_valid,
  input wire logic [3:0] accept_filter,
  input wire logic msg_done,
  output logic buf_wr_ff,
  output logic [3:0] buf_idx_ff,
  output logic fifo_wr_ff,
  output logic [NUM_FILTERS-1:0] filter_enable_ff,
  output logic irq_ff
);
  logic [15:0] dest_ff [4];
  logic [15:0] filter_enable_q;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [3:0] held_dest_ff;
  logic [3:0] last_filter_ff;
  cfbs_pkg::cfbs_state_t state_ff;
  cfbs_pkg::cfbs_state_t nxt_state;
  logic [63:0] dest_flat;
  logic [3:0] sel_dest;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic to_fifo;
  logic buf_full_hit;
  logic [NUM_BUFS-1:0] full_set;
  logic [NUM_BUFS-1:0] ovf_set;
  logic [NUM_BUFS-1:0] full_flags;
  logic [NUM_BUFS-1:0] ovf_flags;
  logic [2:0] irq_ev;
  logic [31:0] rd_mux;
  logic rd_err;
  logic clr_full;
  logic clr_ovf;

  // APB strobes; every access completes in its first access cycle
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  // Pack the four destination registers for nibble slicing
  assign dest_flat = {dest_ff[3], dest_ff[2], dest_ff[1], dest_ff[0]};

  cfbs_dest_select #(
    .NUM_FILTERS(NUM_FILTERS)
  ) u_sel (
    .dest_regs(dest_flat),
    .hit_index(accept_filter),
    .dest_out(sel_dest)
  );

  // Disabled filters never steer anything
  assign hit = accept_valid && filter_enable_q[accept_filter];
  assign to_fifo = (sel_dest == cfbs_pkg::DEST_FIFO);
  assign buf_full_hit = !to_fifo && full_flags[sel_dest];

  // Destination registers, reset to buffer 0 for every filter
  genvar r;
  generate
    for (r = 0; r < 4; r++) begin : g_dest
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dest_ff[r] <= cfbs_pkg::RST_DEST;
        end else if (wr_acc && paddr == cfbs_pkg::OFS_DEST0 + 8'(4*r)) begin
          dest_ff[r] <= pwdata[15:0];
        end
      end
    end
  endgenerate

  // Filter enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filter_enable_q <= cfbs_pkg::RST_ENABLE;
    end else if (wr_acc && paddr == cfbs_pkg::OFS_ENABLE) begin
      filter_enable_q <= pwdata[15:0];
    end
  end
  assign filter_enable_ff = filter_enable_q[NUM_FILTERS-1:0];

  // Steering state: the destination is latched at acceptance so a
  // software rewrite mid-frame cannot split one message
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      cfbs_pkg::CFBS_IDLE: begin
        if (hit && buf_full_hit) begin
          nxt_state = cfbs_pkg::CFBS_DROP;
        end else if (hit) begin
          nxt_state = cfbs_pkg::CFBS_STORE;
        end
      end
      cfbs_pkg::CFBS_STORE: begin
        if (msg_done) begin
          nxt_state = cfbs_pkg::CFBS_IDLE;
        end
      end
      cfbs_pkg::CFBS_DROP: begin
        if (msg_done) begin
          nxt_state = cfbs_pkg::CFBS_IDLE;
        end
      end
      default: nxt_state = cfbs_pkg::CFBS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= cfbs_pkg::CFBS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Capture destination and filter number at acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_dest_ff <= 4'h0;
      last_filter_ff <= 4'h0;
    end else if (state_ff == cfbs_pkg::CFBS_IDLE && hit) begin
      held_dest_ff <= sel_dest;
      last_filter_ff <= accept_filter;
    end
  end

  // Store strobes fire at end of message using the held destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_wr_ff <= 1'b0;
      fifo_wr_ff <= 1'b0;
      buf_idx_ff <= 4'h0;
    end else begin
      buf_wr_ff <= 1'b0;
      fifo_wr_ff <= 1'b0;
      if (state_ff == cfbs_pkg::CFBS_STORE && msg_done) begin
        if (held_dest_ff == cfbs_pkg::DEST_FIFO) begin
          fifo_wr_ff <= 1'b1;
        end else begin
          buf_wr_ff <= 1'b1;
          buf_idx_ff <= held_dest_ff;
        end
      end
    end
  end

  // Flag events per buffer
  genvar b;
  generate
    for (b = 0; b < NUM_BUFS; b++) begin : g_evt
      assign full_set[b] = state_ff == cfbs_pkg::CFBS_STORE && msg_done
        && held_dest_ff == 4'(b);
      assign ovf_set[b] = state_ff == cfbs_pkg::CFBS_IDLE && hit
        && buf_full_hit && sel_dest == 4'(b);
    end
  endgenerate

  assign clr_full = wr_acc && paddr == cfbs_pkg::OFS_FULL;
  assign clr_ovf = wr_acc && paddr == cfbs_pkg::OFS_OVF;

  cfbs_w0c_flags #(
    .WIDTH(NUM_BUFS)
  ) u_full (
    .pclk(pclk),
    .presetn(presetn),
    .set_vec(full_set),
    .clr_en(clr_full),
    .clr_data(pwdata[NUM_BUFS-1:0]),
    .flags_ff(full_flags)
  );

  cfbs_w0c_flags #(
    .WIDTH(NUM_BUFS)
  ) u_ovf (
    .pclk(pclk),
    .presetn(presetn),
    .set_vec(ovf_set),
    .clr_en(clr_ovf),
    .clr_data(pwdata[NUM_BUFS-1:0]),
    .flags_ff(ovf_flags)
  );

  // Interrupt events: buffer store, FIFO store, overflow
  assign irq_ev[cfbs_pkg::IRQ_BUF] = |full_set;
  assign irq_ev[cfbs_pkg::IRQ_FIFO] = state_ff == cfbs_pkg::CFBS_STORE
    && msg_done && held_dest_ff == cfbs_pkg::DEST_FIFO;
  assign irq_ev[cfbs_pkg::IRQ_OVF] = |ovf_set;

  // Sticky status, write one to clear; a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 3'h0;
    end else if (wr_acc && paddr == cfbs_pkg::OFS_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~pwdata[2:0]) | irq_ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_ev;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_ff <= cfbs_pkg::RST_IRQ_MASK;
    end else if (wr_acc && paddr == cfbs_pkg::OFS_IRQ_MASK) begin
      irq_mask_ff <= pwdata[2:0];
    end
  end

  // Registered level interrupt, one cycle behind status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // Read mux; unmapped addresses answer with an error
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      cfbs_pkg::OFS_DEST0: rd_mux = {16'h0000, dest_ff[0]};
      cfbs_pkg::OFS_DEST1: rd_mux = {16'h0000, dest_ff[1]};
      cfbs_pkg::OFS_DEST2: rd_mux = {16'h0000, dest_ff[2]};
      cfbs_pkg::OFS_DEST3: rd_mux = {16'h0000, dest_ff[3]};
      cfbs_pkg::OFS_ENABLE: rd_mux = {16'h0000, filter_enable_q};
      cfbs_pkg::OFS_FULL: rd_mux = {17'h0, full_flags};
      cfbs_pkg::OFS_OVF: rd_mux = {17'h0, ovf_flags};
      cfbs_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
      cfbs_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
      cfbs_pkg::OFS_LAST_HIT: rd_mux = {28'h0, last_filter_ff};
      default: rd_err = 1'b1;
    endcase
  end

  // Read data captured in setup; pready pulses in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && rd_err;
      if (rd_acc) begin
        prdata <= rd_mux;
      end
    end
  end
endmodule // cfbs_steer

/* File: src/cfbs_w0c_flags.sv */
`timescale 1ns/1ps
// Sticky flag bank, set by hardware, cleared by writing zero
module cfbs_w0c_flags #(
  parameter int WIDTH = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic clr_en,
  input wire logic [WIDTH-1:0] clr_data,
  output logic [WIDTH-1:0] flags_ff
);
  // Set beats a simultaneous clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0;
    end else if (clr_en) begin
      flags_ff <= (flags_ff & clr_data) | set_vec;
    end else begin
      flags_ff <= flags_ff | set_vec;
    end
  end
endmodule // cfbs_w0c_flags
